// [include/ist_pkg.sv]
// Shared types and constants for the instruction state timing calculator
package ist_pkg;

    localparam int CNT_W   = 4;
    localparam int COST_W  = 5;
    localparam int WAIT_W  = 3;
    localparam int TOTAL_W = 8;

    // Per-cycle state costs of each access target
    localparam logic [COST_W-1:0] ST_ONCHIP_MEM   = 5'h02;
    localparam logic [COST_W-1:0] ST_PERIPH8_WIDE = 5'h06;
    localparam logic [COST_W-1:0] ST_PERIPH8_BYTE = 5'h03;
    localparam logic [COST_W-1:0] ST_PERIPH16     = 5'h03;
    localparam logic [COST_W-1:0] ST_EXT8_2S_WIDE = 5'h04;
    localparam logic [COST_W-1:0] ST_EXT8_2S_BYTE = 5'h02;
    localparam logic [COST_W-1:0] ST_EXT8_3S_WIDE = 5'h06;
    localparam logic [COST_W-1:0] ST_EXT8_3S_BYTE = 5'h03;
    localparam logic [COST_W-1:0] ST_EXT16_2S     = 5'h02;
    localparam logic [COST_W-1:0] ST_EXT16_3S     = 5'h03;
    localparam logic [COST_W-1:0] ST_INTERNAL     = 5'h01;

    // Cycle counts used by the instruction table
    localparam logic [CNT_W-1:0] N0 = 4'h0;
    localparam logic [CNT_W-1:0] N1 = 4'h1;
    localparam logic [CNT_W-1:0] N2 = 4'h2;
    localparam logic [CNT_W-1:0] N3 = 4'h3;

    typedef enum logic [2:0] {
        IST_TGT_ONCHIP_MEM,
        IST_TGT_PERIPH8,
        IST_TGT_PERIPH16,
        IST_TGT_EXT8_2S,
        IST_TGT_EXT8_3S,
        IST_TGT_EXT16_2S,
        IST_TGT_EXT16_3S
    } ist_target_t;

    typedef enum logic [4:0] {
        IST_ADD_B_IMM, IST_ADD_B_REG, IST_ADD_W_IMM, IST_ADD_W_REG,
        IST_ADD_L_IMM, IST_ADD_L_REG, IST_ADDS, IST_ADDX_IMM, IST_ADDX_REG,
        IST_AND_B_IMM, IST_AND_B_REG, IST_AND_W_IMM, IST_AND_W_REG,
        IST_AND_L_IMM, IST_AND_L_REG, IST_ANDC,
        IST_BAND_REG, IST_BAND_IND, IST_BAND_ABS, IST_BCC_D8
    } ist_instr_t;

endpackage : ist_pkg

// [core/ist_timing.sv]
// Instruction state timing calculator: cycle counts and total execution states
//
// Overview of operation
// RULE1: Total states is sum of count times cost
// RULE2: Each instruction has fixed per-category cycle counts
// RULE3: On-chip memory cycles cost two states each
// RULE4: 8-bit peripheral 6 wide, 3 byte; 16-bit 3
// RULE5: External three-state adds m or 2m waits
// RULE6: Long immediate add/and takes three fetches
// RULE7: Bit-and absolute takes two fetches, one byte
// RULE8: Short conditional branches take two fetches only
`timescale 1ns/10ps
module ist_timing
    import ist_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              start,
    input  ist_instr_t             instr,
    input  ist_target_t            code_tgt,
    input  ist_target_t            stack_tgt,
    input  ist_target_t            data_tgt,
    input  wire logic [WAIT_W-1:0] wait_cnt,
    output logic                   done,
    output logic [CNT_W-1:0]       cnt_fetch,
    output logic [CNT_W-1:0]       cnt_branch,
    output logic [CNT_W-1:0]       cnt_stack,
    output logic [CNT_W-1:0]       cnt_byte,
    output logic [CNT_W-1:0]       cnt_word,
    output logic [CNT_W-1:0]       cnt_int,
    output logic [TOTAL_W-1:0]     total_states
);

    // Cost of one cycle to a target; byte selects the byte-access column
    function automatic logic [COST_W-1:0] cycle_cost(ist_target_t tgt, logic byte_acc,
                                                     logic [WAIT_W-1:0] m);
        logic [COST_W-1:0] mw;
        mw = COST_W'(m);
        unique case (tgt)
            IST_TGT_ONCHIP_MEM: cycle_cost = ST_ONCHIP_MEM;                        // RULE3
            IST_TGT_PERIPH8:    cycle_cost = byte_acc ? ST_PERIPH8_BYTE
                                                      : ST_PERIPH8_WIDE;           // RULE4
            IST_TGT_PERIPH16:   cycle_cost = ST_PERIPH16;                          // RULE4
            IST_TGT_EXT8_2S:    cycle_cost = byte_acc ? ST_EXT8_2S_BYTE : ST_EXT8_2S_WIDE;
            IST_TGT_EXT8_3S:    cycle_cost = byte_acc ? COST_W'(ST_EXT8_3S_BYTE + mw)
                                          : COST_W'(ST_EXT8_3S_WIDE + (mw << 1)); // RULE5
            IST_TGT_EXT16_2S:   cycle_cost = ST_EXT16_2S;
            IST_TGT_EXT16_3S:   cycle_cost = COST_W'(ST_EXT16_3S + mw);            // RULE5
            default:            cycle_cost = ST_ONCHIP_MEM;
        endcase
    endfunction : cycle_cost

    function automatic logic [TOTAL_W-1:0] mul(logic [CNT_W-1:0] n, logic [COST_W-1:0] s);
        mul = TOTAL_W'(n * s);
    endfunction : mul

    logic [CNT_W-1:0]   i_n, j_n, k_n, l_n, m_n, n_n;
    logic [CNT_W-1:0]   fetch_reg, branch_reg, stack_reg, byte_reg, word_reg, int_reg;
    logic [CNT_W-1:0]   fetch_next, branch_next, stack_next, byte_next, word_next, int_next;
    logic [TOTAL_W-1:0] total_reg, total_next;
    logic               done_reg, done_next;

    // Cycle table per instruction
    always_comb begin
        i_n = N1;
        j_n = N0;
        k_n = N0;
        l_n = N0;
        m_n = N0;
        n_n = N0;
        unique case (instr)                                                        // RULE2
            IST_ADD_W_IMM, IST_AND_W_IMM, IST_AND_L_REG: i_n = N2;
            IST_ADD_L_IMM, IST_AND_L_IMM:                i_n = N3;                // RULE6
            IST_BAND_IND, IST_BAND_ABS: begin                                      // RULE7
                i_n = N2;
                l_n = N1;
            end
            IST_BCC_D8:                                  i_n = N2;                // RULE8
            default:                                     i_n = N1;
        endcase
    end

    // A request loads counts and total; done pulses for one cycle
    always_comb begin
        done_next   = start;
        fetch_next  = fetch_reg;
        branch_next = branch_reg;
        stack_next  = stack_reg;
        byte_next   = byte_reg;
        word_next   = word_reg;
        int_next    = int_reg;
        total_next  = total_reg;
        if (start) begin
            fetch_next  = i_n;
            branch_next = j_n;
            stack_next  = k_n;
            byte_next   = l_n;
            word_next   = m_n;
            int_next    = n_n;
            total_next  = TOTAL_W'(mul(i_n, cycle_cost(code_tgt, 1'b0, wait_cnt))
                                 + mul(j_n, cycle_cost(code_tgt, 1'b0, wait_cnt))
                                 + mul(k_n, cycle_cost(stack_tgt, 1'b0, wait_cnt))
                                 + mul(l_n, cycle_cost(data_tgt, 1'b1, wait_cnt))
                                 + mul(m_n, cycle_cost(data_tgt, 1'b0, wait_cnt))
                                 + mul(n_n, ST_INTERNAL));                         // RULE1
        end
    end

    // Results hold until the next request; reset clears them
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            done_reg   <= 1'b0;
            fetch_reg  <= N0;
            branch_reg <= N0;
            stack_reg  <= N0;
            byte_reg   <= N0;
            word_reg   <= N0;
            int_reg    <= N0;
            total_reg  <= '0;
        end else begin
            done_reg   <= done_next;
            fetch_reg  <= fetch_next;
            branch_reg <= branch_next;
            stack_reg  <= stack_next;
            byte_reg   <= byte_next;
            word_reg   <= word_next;
            int_reg    <= int_next;
            total_reg  <= total_next;
        end
    end

    assign done         = done_reg;
    assign cnt_fetch    = fetch_reg;
    assign cnt_branch   = branch_reg;
    assign cnt_stack    = stack_reg;
    assign cnt_byte     = byte_reg;
    assign cnt_word     = word_reg;
    assign cnt_int      = int_reg;
    assign total_states = total_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Reset clears every result; outside a request the results hold
    a_reset_clear: assert property (disable iff (1'b0) !rst_b |=> !done
        && total_states == '0 && cnt_fetch == N0 && cnt_byte == N0)
        else $error("results not cleared by reset");
    a_counts_hold: assert property (!start |=> $stable(cnt_fetch) && $stable(cnt_byte)
        && $stable(total_states))
        else $error("results changed without a request");
    a_done_pulse: assert property (!start |=> !done)
        else $error("done without request");

    // Cycle counts per instruction class
    a_fixed_counts: assert property (start |=> done                               // RULE2
        && cnt_branch == N0 && cnt_stack == N0 && cnt_word == N0 && cnt_int == N0)
        else $error("unexpected cycle category counted");
    a_band_ind: assert property (start && instr == IST_BAND_IND                   // RULE2
        |=> cnt_fetch == N2 && cnt_byte == N1)
        else $error("bit-and indirect cycle counts wrong");
    a_long_imm: assert property (start                                            // RULE6
        && (instr == IST_ADD_L_IMM || instr == IST_AND_L_IMM)
        |=> cnt_fetch == N3 && cnt_byte == N0)
        else $error("long immediate cycle counts wrong");
    a_band_abs: assert property (start && instr == IST_BAND_ABS                   // RULE7
        |=> cnt_fetch == N2 && cnt_byte == N1)
        else $error("bit-and absolute cycle counts wrong");
    a_branch_short: assert property (start && instr == IST_BCC_D8                 // RULE8
        |=> cnt_fetch == N2 && cnt_byte == N0 && cnt_int == N0)
        else $error("short branch cycle counts wrong");

    // Total states against the per-cycle cost of each target
    a_total_is_sum: assert property (done |-> total_states == TOTAL_W'(       // RULE1
        cnt_fetch * $past(cycle_cost(code_tgt, 1'b0, wait_cnt))
        + cnt_byte * $past(cycle_cost(data_tgt, 1'b1, wait_cnt))))
        else $error("total states differ from summed cycle costs");
    a_onchip_cost: assert property (start && instr == IST_ADD_L_IMM                // RULE3
        && code_tgt == IST_TGT_ONCHIP_MEM |=> total_states == TOTAL_W'(6))
        else $error("on-chip fetch cost wrong");
    a_onchip_byte: assert property (start && instr == IST_BAND_ABS                 // RULE3
        && code_tgt == IST_TGT_ONCHIP_MEM && data_tgt == IST_TGT_ONCHIP_MEM
        |=> total_states == TOTAL_W'(6))
        else $error("on-chip byte access cost wrong");
    a_periph8_cost: assert property (start && instr == IST_BAND_ABS                // RULE4
        && code_tgt == IST_TGT_PERIPH8 && data_tgt == IST_TGT_PERIPH8
        |=> total_states == TOTAL_W'(15))
        else $error("8-bit peripheral cost wrong");
    a_periph8_fetch: assert property (start && instr == IST_BCC_D8                // RULE4
        && code_tgt == IST_TGT_PERIPH8 |=> total_states == TOTAL_W'(12))
        else $error("8-bit peripheral fetch cost wrong");
    a_periph16_cost: assert property (start && instr == IST_BCC_D8                // RULE4
        && code_tgt == IST_TGT_PERIPH16 |=> total_states == TOTAL_W'(6))
        else $error("16-bit peripheral fetch cost wrong");
    a_ext_wait_cost: assert property (start && instr == IST_BAND_ABS               // RULE5
        && code_tgt == IST_TGT_EXT16_3S && data_tgt == IST_TGT_EXT8_3S
        |=> total_states == TOTAL_W'(2 * (3 + $past(wait_cnt)) + 3 + $past(wait_cnt)))
        else $error("external wait state cost wrong");
    a_ext8_fetch: assert property (start && instr == IST_BCC_D8                   // RULE5
        && code_tgt == IST_TGT_EXT8_3S
        |=> total_states == TOTAL_W'(2 * (6 + 2 * $past(wait_cnt))))
        else $error("8-bit external fetch wait cost wrong");
    a_ext16_byte: assert property (start && instr == IST_BAND_ABS                 // RULE5
        && code_tgt == IST_TGT_ONCHIP_MEM && data_tgt == IST_TGT_EXT16_3S
        |=> total_states == TOTAL_W'(4 + 3 + $past(wait_cnt)))
        else $error("16-bit external byte wait cost wrong");
    a_ext8_two_state: assert property (start && instr == IST_BAND_ABS
        && code_tgt == IST_TGT_EXT8_2S && data_tgt == IST_TGT_EXT8_2S
        |=> total_states == TOTAL_W'(10))
        else $error("8-bit two-state external cost wrong");
    a_ext16_two_state: assert property (start && instr == IST_BCC_D8
        && code_tgt == IST_TGT_EXT16_2S |=> total_states == TOTAL_W'(4))
        else $error("16-bit two-state external cost wrong");

    // Scenarios worth seeing
    c_branch: cover property (start && instr == IST_BCC_D8 ##1 done);
    c_band_ext: cover property (start && instr == IST_BAND_ABS && data_tgt == IST_TGT_EXT8_3S);
    c_long_periph: cover property (start && instr == IST_ADD_L_IMM
        && code_tgt == IST_TGT_PERIPH8);
    c_back_to_back: cover property (start ##1 start);
    c_ext8_wait: cover property (start && code_tgt == IST_TGT_EXT8_3S
        && wait_cnt == 3'h7);

endmodule : ist_timing

// [sim/ist_bus_model.sv]
// Access target and wait model for the memories, peripherals and external devices
`timescale 1ns/10ps
module ist_bus_model
    import ist_pkg::*;
(
    input  ist_target_t             req_code,
    input  ist_target_t             req_data,
    input  wire logic [WAIT_W-1:0]  req_wait,
    output ist_target_t             code_tgt,
    output ist_target_t             stack_tgt,
    output ist_target_t             data_tgt,
    output logic [WAIT_W-1:0]       wait_cnt
);
    // Stack lives in the same space as the code
    assign code_tgt  = req_code;
    assign stack_tgt = req_code;
    assign data_tgt  = req_data;
    assign wait_cnt  = req_wait;
endmodule : ist_bus_model

// [sim/tb.sv]
// Self-checking bench for the instruction state timing calculator
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
    import ist_pkg::*;
    logic               clk      = 1'b0;
    logic               rst_b    = 1'b0;
    logic               start    = 1'b0;
    ist_instr_t         instr    = IST_ADD_B_IMM;
    ist_target_t        req_code = IST_TGT_ONCHIP_MEM;
    ist_target_t        req_data = IST_TGT_ONCHIP_MEM;
    logic [WAIT_W-1:0]  req_wait = 3'h0;
    ist_target_t        code_tgt, stack_tgt, data_tgt;
    logic [WAIT_W-1:0]  wait_cnt;
    logic               done;
    logic [CNT_W-1:0]   cnt_fetch, cnt_branch, cnt_stack, cnt_byte, cnt_word, cnt_int;
    logic [TOTAL_W-1:0] total_states;
    int                 bad_count = 0;
    int                 n_checks  = 0;
    int                 cycles    = 0;
    int                 fi [20]   = '{1,1,2,1,3,1,1,1,1,1,1,2,1,3,2,1,1,2,2,2};

    ist_bus_model ist_bus_model_inst (.req_code(req_code), .req_data(req_data),
        .req_wait(req_wait), .code_tgt(code_tgt), .stack_tgt(stack_tgt),
        .data_tgt(data_tgt), .wait_cnt(wait_cnt));
    ist_timing ist_timing_inst (.clk(clk), .rst_b(rst_b), .start(start), .instr(instr),
        .code_tgt(code_tgt), .stack_tgt(stack_tgt), .data_tgt(data_tgt),
        .wait_cnt(wait_cnt), .done(done), .cnt_fetch(cnt_fetch), .cnt_branch(cnt_branch),
        .cnt_stack(cnt_stack), .cnt_byte(cnt_byte), .cnt_word(cnt_word),
        .cnt_int(cnt_int), .total_states(total_states));

    initial begin
        forever #25 clk = ~clk;
    end

    // Per-cycle state cost of a target; b selects the byte column
    function automatic int cw(ist_target_t t, int m, bit b);
        case (t)
            IST_TGT_ONCHIP_MEM: return 2;
            IST_TGT_PERIPH8:    return b ? 3 : 6;
            IST_TGT_PERIPH16:   return 3;
            IST_TGT_EXT8_2S:    return b ? 2 : 4;
            IST_TGT_EXT8_3S:    return b ? 3 + m : 6 + 2 * m;
            IST_TGT_EXT16_2S:   return 2;
            default:            return 3 + m;
        endcase
    endfunction : cw

    task automatic run(ist_instr_t i, ist_target_t c, ist_target_t d, int m);
        @(posedge clk);
        start    <= 1'b1;
        instr    <= i;
        req_code <= c;
        req_data <= d;
        req_wait <= 3'(m);
    endtask : run

    task automatic chk(ist_instr_t i, ist_target_t c, ist_target_t d, int m);
        int l;
        @(negedge clk);
        l = (i == IST_BAND_IND || i == IST_BAND_ABS) ? 1 : 0;
        `CHK(done, 1'b1)
        `CHK(cnt_fetch, 4'(fi[i]))
        `CHK(cnt_byte, 4'(l))
        `CHK({cnt_branch, cnt_stack, cnt_word, cnt_int}, 16'h0000)
        `CHK(total_states, 8'(fi[i] * cw(c, m, 1'b0) + l * cw(d, m, 1'b1)))
    endtask : chk

    task automatic one(ist_instr_t i, ist_target_t c, ist_target_t d, int m);
        run(i, c, d, m);
        @(posedge clk);
        start <= 1'b0;
        chk(i, c, d, m);
    endtask : one

    task automatic t_table();
        for (int k = 0; k < 20; k++) begin
            one(ist_instr_t'(k), IST_TGT_ONCHIP_MEM, IST_TGT_ONCHIP_MEM, 0);
        end
        @(negedge clk);
        `CHK(done, 1'b0)
        `CHK(total_states, 8'h04)
        $display("table test done");
    endtask : t_table

    task automatic t_targets();
        for (int c = 0; c < 7; c++) begin
            for (int d = 0; d < 7; d++) begin
                one(IST_BAND_ABS, ist_target_t'(c), ist_target_t'(d), (c + d) % 8);
                one(IST_BCC_D8, ist_target_t'(c), ist_target_t'(d), 7);
            end
        end
        $display("target test done");
    endtask : t_targets

    task automatic t_b2b();
        run(IST_ADD_L_IMM, IST_TGT_EXT8_3S, IST_TGT_PERIPH8, 3);
        run(IST_AND_L_IMM, IST_TGT_PERIPH8, IST_TGT_EXT16_3S, 2);
        chk(IST_ADD_L_IMM, IST_TGT_EXT8_3S, IST_TGT_PERIPH8, 3);
        @(posedge clk);
        start <= 1'b0;
        chk(IST_AND_L_IMM, IST_TGT_PERIPH8, IST_TGT_EXT16_3S, 2);
        $display("back to back test done");
    endtask : t_b2b

    task automatic t_reset();
        one(IST_ADD_L_IMM, IST_TGT_EXT8_3S, IST_TGT_EXT8_3S, 7);
        @(posedge clk);
        rst_b <= 1'b0;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        `CHK({done, cnt_fetch, total_states}, 13'h0000)
        @(negedge clk);
        `CHK({done, cnt_fetch, total_states}, 13'h0000)
        one(IST_BCC_D8, IST_TGT_PERIPH16, IST_TGT_ONCHIP_MEM, 0);
        $display("reset test done");
    endtask : t_reset

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            report_and_stop();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        `CHK({done, total_states}, 9'h000)
        t_table();
        t_targets();
        t_b2b();
        t_reset();
        report_and_stop();
    end
endmodule : tb
